/* File: hw/digital_integrate_sampler.sv */
`timescale 1ns/1ps
// ==========================================
// Word FIFO
module sample_fifo #(
	parameter int W = 32,
	parameter int D = 32
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp_r;
	logic [AW:0]  rp_r;
	logic         full;
	logic         empty;

	assign empty     = (wp_r == rp_r);
	assign full      = (wp_r[AW] != rp_r[AW]) &&
	                   (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp_r[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (in_valid && !full)
			mem[wp_r[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			wp_r <= '0;
		else if (in_valid && !full)
			wp_r <= wp_r + 1'b1;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rp_r <= '0;
		else if (out_ready && !empty)
			rp_r <= rp_r + 1'b1;
	end
endmodule : sample_fifo

// What this block does
// [R1] Gapped timing idles gap_width steps of 31.25 ns between regions.
// [R2] Config bit 7 set enables gapped timing for integrating slots only.
// [R3] Config bit 7 clear: positive region follows negative immediately.
// [R4] Gapped or continuous combine freely with single or double layout.
// [R5] Keep dark sum of negative samples; output has dark subtracted.
// [R6] FIFO content 0x3 pushes 16-bit words, 0x4 pushes 32-bit words.
// [R7] Dark values readable at 0x65/0x71/0x75 (A), 0x69/0x79/0x7d (B).
// [R8] Host sets channel offsets to 0x1F00 when dark goes to FIFO.
// [R9] Host checks single-pair saturation from output and dark values.
// [R10] Host checks double-pair saturation with doubled region width.
// [R11] Bit 12 enables integrate mode for slot A, bit 13 for slot B.
// [R12] Host writes 0x1D to mode upper byte to make integrator a buffer.
// [R13] Mode bit 7 or integrate mode turns integrator into buffer.
// [R14] Routing value 0xAE65 bypasses the band-pass stage.
// [R15] Host sets converter timing to 0x0040 for 1 MHz conversions.
// [R16] Integration config acts only while integrate mode is active.
// [R17] Pulse connect gates photodiode for LED pulse time, no LED drive.
// [R18] Host clears LED select bits of a slot to pick pulse connect.
// [R19] One conversion per microsecond; subtract negative, add positive.
// [R20] Single layout: negative at offset+9 for width, positive follows.
// [R21] Double layout: positive twice width, then second negative width.
// [R22] Config bit 5 (A) or 6 (B) set picks single, clear picks double.
// [R23] Gap delays positive region; gap time contributes no samples.
module digital_integrate_sampler (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Register port
	input  wire logic [7:0]   reg_addr,
	input  wire logic [15:0]  reg_wdata,
	input  wire logic         reg_wr,
	output logic [15:0]       reg_rdata,
	// Slot timing from the timing core
	input  wire logic         slot_start,
	input  wire logic         slot_is_b,
	input  wire logic [7:0]   region_start_offset,
	input  wire logic [7:0]   region_width,
	input  wire logic [7:0]   gap_width_slot_a,
	input  wire logic [7:0]   gap_width_slot_b,
	input  wire logic [2:0]   fifo_content_a,
	input  wire logic [2:0]   fifo_content_b,
	// Converter
	output logic              adc_conv,
	input  wire logic         adc_valid,
	input  wire logic [13:0]  adc_data,
	// Front end control
	input  wire logic         led_pulse,
	input  wire logic [1:0]   led_sel_a,
	input  wire logic [1:0]   led_sel_b,
	output logic              led_drive,
	output logic              pd_connect,
	output logic [1:0]        integrator_buffer,
	output logic [1:0]        bandpass_bypass,
	// Sample to decimation
	output logic              sample_valid,
	output logic [31:0]       sample_data,
	output logic              busy,
	// FIFO drain
	output logic              fifo_rd_valid,
	input  wire logic         fifo_rd_ready,
	output logic [31:0]       fifo_rd_data
);
	import dis_pkg::*;

	// ==========================================
	// Registers
	logic [15:0] mode_a_r, route_a_r, mode_b_r, route_b_r;
	logic [15:0] adc_tim_r, int_en_r, int_cfg_r;
	logic [31:0] out_a_r, dark_a_r, out_b_r, dark_b_r;
	logic [1:0]  slot_int;

	assign slot_int[0] = int_en_r[BIT_INT_EN_A]; // R11
	assign slot_int[1] = int_en_r[BIT_INT_EN_B]; // R11

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_a_r  <= RST_REG;
			route_a_r <= RST_REG;
			mode_b_r  <= RST_REG;
			route_b_r <= RST_REG;
			adc_tim_r <= RST_REG;
			int_en_r  <= RST_REG;
			int_cfg_r <= RST_REG;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				OFS_MODE_A:  mode_a_r  <= reg_wdata;
				OFS_ROUTE_A: route_a_r <= reg_wdata;
				OFS_MODE_B:  mode_b_r  <= reg_wdata;
				OFS_ROUTE_B: route_b_r <= reg_wdata;
				OFS_ADC_TIM: adc_tim_r <= reg_wdata;
				OFS_INT_EN:  int_en_r  <= reg_wdata;
				OFS_INT_CFG: int_cfg_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Registered read, one cycle behind the address
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= RST_REG;
		else
		begin
			case (reg_addr)
				OFS_MODE_A:  reg_rdata <= mode_a_r;
				OFS_ROUTE_A: reg_rdata <= route_a_r;
				OFS_MODE_B:  reg_rdata <= mode_b_r;
				OFS_ROUTE_B: reg_rdata <= route_b_r;
				OFS_ADC_TIM: reg_rdata <= adc_tim_r;
				OFS_INT_EN:  reg_rdata <= int_en_r;
				OFS_INT_CFG: reg_rdata <= int_cfg_r;
				OFS_OUT_A0:  reg_rdata <= out_a_r[15:0];
				OFS_OUT_A1:  reg_rdata <= out_a_r[15:0];
				OFS_OUT_A2:  reg_rdata <= out_a_r[31:16];
				OFS_DARK_A0: reg_rdata <= dark_a_r[15:0];  // R7
				OFS_DARK_A1: reg_rdata <= dark_a_r[15:0];  // R7
				OFS_DARK_A2: reg_rdata <= dark_a_r[31:16]; // R7
				OFS_OUT_B0:  reg_rdata <= out_b_r[15:0];
				OFS_OUT_B1:  reg_rdata <= out_b_r[15:0];
				OFS_OUT_B2:  reg_rdata <= out_b_r[31:16];
				OFS_DARK_B0: reg_rdata <= dark_b_r[15:0];  // R7
				OFS_DARK_B1: reg_rdata <= dark_b_r[15:0];  // R7
				OFS_DARK_B2: reg_rdata <= dark_b_r[31:16]; // R7
				default:     reg_rdata <= RST_REG;
			endcase
		end
	end

	// ==========================================
	// Analog path steering
	assign integrator_buffer[0] = slot_int[0] |
	                              mode_a_r[BIT_INT_BUF]; // R13
	assign integrator_buffer[1] = slot_int[1] |
	                              mode_b_r[BIT_INT_BUF]; // R13
	assign bandpass_bypass[0] = (route_a_r == ROUTE_BYPASS); // R14
	assign bandpass_bypass[1] = (route_b_r == ROUTE_BYPASS); // R14

	// Zero LED select means the pulse gates the input instead
	logic [1:0] cur_sel;
	logic       pconn;
	assign cur_sel    = slot_is_b ? led_sel_b : led_sel_a;
	assign pconn      = (cur_sel == 2'h0);
	assign led_drive  = led_pulse & !pconn;               // R17
	assign pd_connect = pconn ? led_pulse : 1'b1;         // R17

	// ==========================================
	// Time bases
	seq_state_t  st_r;
	logic [6:0]  us_cnt_r;
	logic        us_tick;
	logic [15:0] ph_r;
	logic        gap_tick;

	assign us_tick = (us_cnt_r == 7'(CONV_CYC - 1));

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			us_cnt_r <= '0;
		else if (slot_start || us_tick)
			us_cnt_r <= '0;
		else
			us_cnt_r <= us_cnt_r + 7'h01;
	end

	// Fractional phase: 31.25 ns is not a whole number of cycles
	assign gap_tick = (ph_r + 16'(CLK_PS)) >= 16'(GAP_STEP_PS);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ph_r <= '0;
		else if (st_r != ST_GAP)
			ph_r <= '0;
		else if (gap_tick)
			ph_r <= ph_r + 16'(CLK_PS) - 16'(GAP_STEP_PS); // R1
		else
			ph_r <= ph_r + 16'(CLK_PS);
	end

	// ==========================================
	// Region sequencer
	logic        cur_b_r, gapped_r, single_r;
	logic [8:0]  cnt_r;
	logic [7:0]  width_r, gap_r;
	logic [2:0]  fsel_r;
	logic        pend_pos_r;
	logic [31:0] neg_r, pos_r, dark_w, out_w;
	logic        fifo_in_ready;
	logic        widx_r;
	logic        push_ok;

	assign push_ok = (fsel_r == FIFO_SEL_16) ||
	                 (fsel_r == FIFO_SEL_32);
	assign adc_conv = us_tick && cnt_r != '0 &&
	                  (st_r == ST_NEG1 || st_r == ST_POS ||
	                   st_r == ST_NEG2); // R19
	assign busy = (st_r != ST_IDLE);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r     <= ST_IDLE;
			cnt_r    <= '0;
			cur_b_r  <= 1'b0;
			gapped_r <= 1'b0;
			single_r <= 1'b0;
			width_r  <= '0;
			gap_r    <= '0;
			fsel_r   <= '0;
			widx_r   <= 1'b0;
		end
		else
		begin
			case (st_r)
				ST_IDLE:
					if (slot_start && slot_int[slot_is_b])
					begin
						// Config is latched only for integrating slots
						cur_b_r  <= slot_is_b;
						gapped_r <= int_cfg_r[BIT_GAPPED]; // R2 R3 R16
						single_r <= slot_is_b ?
						            int_cfg_r[BIT_SINGLE_B] :
						            int_cfg_r[BIT_SINGLE_A]; // R22 R16
						width_r  <= region_width;
						gap_r    <= slot_is_b ? gap_width_slot_b :
						                        gap_width_slot_a;
						fsel_r   <= slot_is_b ? fifo_content_b :
						                        fifo_content_a;
						cnt_r    <= {1'b0, region_start_offset} +
						            LEAD_EXTRA; // R20
						st_r     <= ST_LEAD;
					end
				ST_LEAD:
					if (cnt_r == '0)
					begin
						cnt_r <= {1'b0, width_r};
						st_r  <= ST_NEG1;
					end
					else if (us_tick)
						cnt_r <= cnt_r - 9'h001;
				ST_NEG1:
					if (cnt_r == '0)
					begin
						cnt_r <= gapped_r ? {1'b0, gap_r} :
						         (single_r ? {1'b0, width_r} :
						          {width_r, 1'b0}); // R4 R21
						st_r  <= gapped_r ? ST_GAP : ST_POS; // R3 R4
					end
					else if (us_tick)
						cnt_r <= cnt_r - 9'h001;
				ST_GAP:
					// No conversions issued here
					if (cnt_r == '0)
					begin
						cnt_r <= single_r ? {1'b0, width_r} :
						         {width_r, 1'b0}; // R21
						st_r  <= ST_POS; // R23
					end
					else if (gap_tick)
						cnt_r <= cnt_r - 9'h001; // R1
				ST_POS:
					if (cnt_r == '0)
					begin
						cnt_r <= {1'b0, width_r};
						st_r  <= single_r ? ST_FIN : ST_NEG2; // R20 R21
					end
					else if (us_tick)
						cnt_r <= cnt_r - 9'h001;
				ST_NEG2:
					if (cnt_r == '0)
						st_r <= ST_FIN;
					else if (us_tick)
						cnt_r <= cnt_r - 9'h001;
				ST_FIN:
					// Wait a full conversion so the last result lands
					if (us_tick)
					begin
						widx_r <= 1'b0;
						st_r   <= push_ok ? ST_PUSH : ST_IDLE;
					end
				ST_PUSH:
					if (fifo_in_ready)
					begin
						widx_r <= 1'b1;
						if (widx_r)
							st_r <= ST_IDLE;
					end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Accumulation
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pend_pos_r <= 1'b0;
		else if (adc_conv)
			pend_pos_r <= (st_r == ST_POS);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			neg_r <= '0;
			pos_r <= '0;
		end
		else if (st_r == ST_IDLE)
		begin
			neg_r <= '0;
			pos_r <= '0;
		end
		else if (adc_valid && st_r != ST_PUSH)
		begin
			if (pend_pos_r)
				pos_r <= pos_r + 32'(adc_data); // R19
			else
				neg_r <= neg_r + 32'(adc_data); // R19 R5
		end
	end

	assign dark_w = neg_r;          // R5
	assign out_w  = pos_r - neg_r;  // R5

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			out_a_r      <= '0;
			dark_a_r     <= '0;
			out_b_r      <= '0;
			dark_b_r     <= '0;
			sample_valid <= 1'b0;
			sample_data  <= '0;
		end
		else
		begin
			sample_valid <= 1'b0;
			if (st_r == ST_FIN && us_tick)
			begin
				sample_valid <= 1'b1;
				sample_data  <= out_w;
				if (cur_b_r)
				begin
					out_b_r  <= out_w;
					dark_b_r <= dark_w; // R5
				end
				else
				begin
					out_a_r  <= out_w;
					dark_a_r <= dark_w; // R5
				end
			end
		end
	end

	// ==========================================
	// FIFO loading: output word first, then dark word
	logic [31:0] sel_out, sel_dark, push_word;
	assign sel_out  = cur_b_r ? out_b_r  : out_a_r;
	assign sel_dark = cur_b_r ? dark_b_r : dark_a_r;
	assign push_word = (fsel_r == FIFO_SEL_16) ?
	    {16'h0000, (widx_r ? sel_dark[15:0] : sel_out[15:0])} :
	    (widx_r ? sel_dark : sel_out); // R6

	sample_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) i_sample_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (st_r == ST_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (fifo_rd_valid),
		.out_ready (fifo_rd_ready),
		.out_data  (fifo_rd_data)
	);
endmodule : digital_integrate_sampler

/* File: shared/dis_pkg.sv */
package dis_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] OFS_MODE_A   = 8'h42;
	localparam logic [7:0] OFS_ROUTE_A  = 8'h43;
	localparam logic [7:0] OFS_MODE_B   = 8'h44;
	localparam logic [7:0] OFS_ROUTE_B  = 8'h45;
	localparam logic [7:0] OFS_ADC_TIM  = 8'h4e;
	localparam logic [7:0] OFS_INT_EN   = 8'h58;
	localparam logic [7:0] OFS_INT_CFG  = 8'h5a;
	localparam logic [7:0] OFS_OUT_A0   = 8'h64;
	localparam logic [7:0] OFS_DARK_A0  = 8'h65;
	localparam logic [7:0] OFS_OUT_B0   = 8'h68;
	localparam logic [7:0] OFS_DARK_B0  = 8'h69;
	localparam logic [7:0] OFS_OUT_A1   = 8'h70;
	localparam logic [7:0] OFS_DARK_A1  = 8'h71;
	localparam logic [7:0] OFS_OUT_A2   = 8'h74;
	localparam logic [7:0] OFS_DARK_A2  = 8'h75;
	localparam logic [7:0] OFS_OUT_B1   = 8'h78;
	localparam logic [7:0] OFS_DARK_B1  = 8'h79;
	localparam logic [7:0] OFS_OUT_B2   = 8'h7c;
	localparam logic [7:0] OFS_DARK_B2  = 8'h7d;
	// ==========================================
	// Reset values
	localparam logic [15:0] RST_REG     = 16'h0000;
	// ==========================================
	// Field positions
	localparam int BIT_INT_EN_A = 12;
	localparam int BIT_INT_EN_B = 13;
	localparam int BIT_GAPPED   = 7;
	localparam int BIT_SINGLE_A = 5;
	localparam int BIT_SINGLE_B = 6;
	localparam int BIT_INT_BUF  = 7;
	localparam logic [15:0] ROUTE_BYPASS = 16'hae65;
	localparam logic [2:0] FIFO_SEL_16  = 3'h3;
	localparam logic [2:0] FIFO_SEL_32  = 3'h4;
	localparam logic [8:0] LEAD_EXTRA   = 9'h009;
	// ==========================================
	// Timing
	localparam int CLK_PS       = 10000;
	localparam int CONV_NS      = 1000;
	localparam int CONV_CYC     = CONV_NS * 1000 / CLK_PS;
	localparam int GAP_STEP_PS  = 31250;
	// ==========================================
	// Buffering
	localparam int FIFO_W       = 32;
	localparam int FIFO_D       = 32;
	typedef enum logic [2:0] {
		ST_IDLE, ST_LEAD, ST_NEG1, ST_GAP,
		ST_POS, ST_NEG2, ST_FIN, ST_PUSH
	} seq_state_t;
endpackage : dis_pkg

/* File: bench/front_end_model.sv */
`timescale 1ns/1ps
// ==========================================
// Converter side of the front end
module front_end_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Converter handshake
	input  wire logic        adc_conv,
	input  wire logic        busy,
	input  wire logic        slow,
	output logic             adc_valid,
	output logic [13:0]      adc_data
);
	logic [7:0] k_r;
	logic [7:0] wait_r;
	logic       pend_r;

	// Squares make every region sum distinct, so a swapped sign shows
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			k_r <= 8'h00;
			wait_r <= 8'h00;
			pend_r <= 1'b0;
			adc_valid <= 1'b0;
			adc_data <= 14'h3fff;
		end
		else
		begin
			adc_valid <= 1'b0;
			if (!busy)
				k_r <= 8'h00;
			if (adc_conv)
			begin
				pend_r <= 1'b1;
				wait_r <= slow ? 8'h3c : 8'h00;
			end
			else if (pend_r && wait_r != 8'h00)
				wait_r <= wait_r - 8'h01;
			else if (pend_r)
			begin
				pend_r <= 1'b0;
				adc_valid <= 1'b1;
				k_r <= k_r + 8'h01;
				adc_data <= 14'((k_r + 8'h01) * (k_r + 8'h01));
			end
			// Released data must not look like the last result
			else if (adc_valid)
				adc_data <= ~adc_data;
		end
	end
endmodule : front_end_model

/* File: bench/digital_integrate_sampler_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker
module dis_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	// Front end and converter
	input wire logic        adc_conv,
	input wire logic        led_pulse,
	input wire logic        led_drive,
	input wire logic        pd_connect,
	input wire logic [1:0]  integrator_buffer,
	input wire logic [1:0]  bandpass_bypass,
	// Results
	input wire logic        sample_valid,
	input wire logic        busy,
	input wire logic        fifo_rd_valid,
	input wire logic        fifo_rd_ready,
	input wire logic [31:0] fifo_rd_data
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	logic [15:0] busy_cyc_r;

	// Saturates so a stalled slot cannot wrap into a false early count
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			busy_cyc_r <= 16'h0000;
		else if (!busy)
			busy_cyc_r <= 16'h0000;
		else if (busy_cyc_r != 16'hffff)
			busy_cyc_r <= busy_cyc_r + 16'h0001;
	end

	bypass_set_a: assert property (reg_wr && reg_addr == 8'h43 |=>
		bandpass_bypass[0] == ($past(reg_wdata) == 16'hae65))
		else $error("bypass flag wrong");
	int_buffer_a: assert property (reg_wr && reg_addr == 8'h58 &&
		reg_wdata[12] |=> integrator_buffer[0]) else $error("no buffer");
	drive_gate_a: assert property (led_drive |-> led_pulse && pd_connect)
		else $error("led drive wrong");
	pd_gate_a: assert property (!pd_connect |-> !led_pulse && !led_drive)
		else $error("pd gate wrong");
	valid_pulse_a: assert property (sample_valid |=> !sample_valid)
		else $error("sample valid too long");
	conv_space_a: assert property (adc_conv |=> !adc_conv [*8])
		else $error("conversions too close");
	conv_busy_a: assert property (adc_conv |-> busy)
		else $error("conversion while idle");
	lead_time_a: assert property (adc_conv |-> busy_cyc_r >= 16'h0320)
		else $error("conversion before lead");
	fifo_hold_a: assert property (fifo_rd_valid && !fifo_rd_ready |=>
		fifo_rd_valid && $stable(fifo_rd_data)) else $error("fifo head lost");

	cover property (sample_valid);
	cover property (fifo_rd_valid && fifo_rd_ready);
	cover property (adc_conv && !pd_connect);
endmodule : dis_checker

bind digital_integrate_sampler dis_checker i_dis_checker (.clk, .resetn,
	.reg_addr, .reg_wdata, .reg_wr, .adc_conv, .led_pulse, .led_drive,
	.pd_connect, .integrator_buffer, .bandpass_bypass, .sample_valid,
	.busy, .fifo_rd_valid, .fifo_rd_ready, .fifo_rd_data);

/* File: bench/test_digital_integrate_sampler.sv */
`timescale 1ns/1ps
module test_digital_integrate_sampler;
	import dis_pkg::*;
	// ==========================================
	// Stimulus and observed signals
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        slot_start = 1'b0;
	logic        slot_is_b = 1'b0;
	logic [7:0]  region_start_offset = 8'h02;
	logic [7:0]  region_width = 8'h02;
	logic [7:0]  gap_width_slot_a = 8'h40;
	logic [7:0]  gap_width_slot_b = 8'h40;
	logic [2:0]  fifo_content_a = 3'h4;
	logic [2:0]  fifo_content_b = 3'h3;
	logic        led_pulse = 1'b0;
	logic [1:0]  led_sel_a = 2'h1;
	logic [1:0]  led_sel_b = 2'h1;
	logic        fifo_rd_ready = 1'b0;
	logic        slow = 1'b0;
	logic [15:0] reg_rdata;
	logic        adc_conv, adc_valid, led_drive, pd_connect;
	logic        sample_valid, busy, fifo_rd_valid;
	logic [13:0] adc_data;
	logic [1:0]  integrator_buffer, bandpass_bypass;
	logic [31:0] sample_data, fifo_rd_data, got;
	int          mismatches = 0;
	int          n_tests = 0;

	digital_integrate_sampler i_digital_integrate_sampler (.clk, .resetn,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .slot_start, .slot_is_b,
		.region_start_offset, .region_width, .gap_width_slot_a,
		.gap_width_slot_b, .fifo_content_a, .fifo_content_b, .adc_conv,
		.adc_valid, .adc_data, .led_pulse, .led_sel_a, .led_sel_b,
		.led_drive, .pd_connect, .integrator_buffer, .bandpass_bypass,
		.sample_valid, .sample_data, .busy, .fifo_rd_valid, .fifo_rd_ready,
		.fifo_rd_data);
	front_end_model i_front_end_model (.clk, .resetn, .adc_conv, .busy,
		.slow, .adc_valid, .adc_data);

	always #5 clk = ~clk;

	// ==========================================
	// Shared tasks
	task automatic cmp(input string w, input logic [31:0] e,
		input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", w, e, s);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask : rd

	task automatic run_slot(input logic b, output int n);
		while (busy !== 1'b0)
			@(posedge clk);
		@(posedge clk);
		slot_is_b <= b;
		slot_start <= 1'b1;
		@(posedge clk);
		slot_start <= 1'b0;
		n = 0;
		while (sample_valid !== 1'b1 && n < 9000)
		begin
			@(posedge clk);
			#1 n++;
		end
		got = sample_data;
	endtask : run_slot

	task automatic pop(input string w, input logic [31:0] e);
		int t;
		t = 0;
		// Let the pop of the previous call settle first
		#1;
		while (fifo_rd_valid !== 1'b1 && t < 500)
		begin
			@(posedge clk);
			#1 t++;
		end
		cmp(w, e, fifo_rd_data);
		@(posedge clk);
		fifo_rd_ready <= 1'b1;
		@(posedge clk);
		fifo_rd_ready <= 1'b0;
	endtask : pop

	function automatic logic [31:0] sq_sum(input int a, input int b);
		logic [31:0] s;
		s = 32'h0;
		for (int k = a; k <= b; k++)
			s += 32'(k * k);
		return s;
	endfunction : sq_sum

	// ==========================================
	// Scenarios
	task automatic test_regs;
		logic [15:0] d;
		rd(OFS_INT_EN, d);
		cmp("int_en reset", 32'h0, 32'(d));
		wr(8'h18, 16'h1f00);
		rd(8'h18, d);
		cmp("unmapped", 32'h0, 32'(d));
		wr(OFS_DARK_A0, 16'h5555);
		rd(OFS_DARK_A0, d);
		cmp("dark read only", 32'h0, 32'(d));
		wr(OFS_MODE_A, 16'h1d00);
		wr(OFS_ROUTE_A, ROUTE_BYPASS);
		wr(OFS_ADC_TIM, 16'h0040);
		wr(OFS_INT_EN, 16'h1000);
		rd(OFS_ADC_TIM, d);
		cmp("adc timing", 32'h40, 32'(d));
		cmp("bypass", 32'h1, 32'(bandpass_bypass));
		cmp("buffer", 32'h1, 32'(integrator_buffer));
		$display("test_regs done");
	endtask : test_regs

	task automatic test_pulse;
		@(posedge clk);
		led_sel_a <= 2'h0;
		led_pulse <= 1'b1;
		#1 cmp("pd on", 32'h1, 32'(pd_connect));
		cmp("led off", 32'h0, 32'(led_drive));
		@(posedge clk);
		led_pulse <= 1'b0;
		#1 cmp("pd off", 32'h0, 32'(pd_connect));
		@(posedge clk);
		led_sel_a <= 2'h1;
		led_pulse <= 1'b1;
		#1 cmp("led on", 32'h1, 32'(led_drive));
		@(posedge clk);
		led_pulse <= 1'b0;
		$display("test_pulse done");
	endtask : test_pulse

	// Width 2: samples 1..8 squared, 1..4 in single runs; odd runs use the slow converter
	task automatic test_layouts;
		int n[4];
		logic [31:0] o;
		logic [31:0] dk;
		logic [15:0] d;
		int          w;
		logic        sat;
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_INT_CFG, {8'h00, i[1], 1'b0, i[0], 5'h00});
			slow <= i[0];
			run_slot(1'b0, n[i]);
			dk = i[0] ? sq_sum(1, 2) : sq_sum(1, 2) + sq_sum(7, 8);
			o = (i[0] ? sq_sum(3, 4) : sq_sum(3, 6)) - dk;
			cmp("sample", o, got);
			// Host saturation test, one pulse, LED at least as wide
			w = i[0] ? 2 : 4;
			sat = (int'(signed'(got)) / w + int'(dk) / w) > 32'sh3fff;
			cmp("saturation", 32'h0, 32'(sat));
			pop("fifo out", o);
			pop("fifo dark", dk);
			rd(OFS_DARK_A1, d);
			cmp("dark low", dk & 32'hffff, 32'(d));
			rd(OFS_DARK_A2, d);
			cmp("dark high", dk >> 16, 32'(d));
		end
		cmp("gap single", 32'h1, 32'(n[3] - n[1] inside {[195:210]}));
		cmp("gap double", 32'h1, 32'(n[2] - n[0] inside {[195:210]}));
		$display("test_layouts done");
	endtask : test_layouts

	task automatic test_slot_b;
		int n;
		logic [15:0] d;
		@(posedge clk);
		slot_is_b <= 1'b1;
		slot_start <= 1'b1;
		@(posedge clk);
		slot_start <= 1'b0;
		#1 cmp("b disabled", 32'h0, 32'(busy));
		wr(OFS_INT_EN, 16'h3000);
		wr(OFS_INT_CFG, 16'h0040);
		run_slot(1'b1, n);
		cmp("b sample", 32'd20, got);
		pop("b fifo out", 32'd20);
		pop("b fifo dark", 32'd5);
		rd(OFS_DARK_B1, d);
		cmp("b dark", 32'd5, 32'(d));
		// Slot B double gapped, content code that pushes nothing
		wr(OFS_INT_CFG, 16'h0080);
		fifo_content_b <= 3'h0;
		run_slot(1'b1, n);
		cmp("b double gapped", 32'hffffffe0, got);
		repeat (4) @(posedge clk);
		#1 cmp("b no push", 32'h0, 32'(fifo_rd_valid));
		$display("test_slot_b done");
	endtask : test_slot_b

	task automatic test_fill;
		int n;
		region_width <= 8'h01;
		wr(OFS_INT_CFG, 16'h0020);
		repeat (17) run_slot(1'b0, n);
		repeat (300) @(posedge clk);
		#1 cmp("full stall", 32'h1, 32'(busy));
		repeat (17)
		begin
			pop("fill out", 32'h3);
			pop("fill dark", 32'h1);
		end
		#1 cmp("drained", 32'h0, 32'(fifo_rd_valid));
		$display("test_fill done");
	endtask : test_fill

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		#900000;
		mismatches++;
		print_verdict;
	end

	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		test_regs;
		test_pulse;
		test_layouts;
		test_slot_b;
		test_fill;
		print_verdict;
	end
endmodule : test_digital_integrate_sampler
